// >>> logic/timer1_compare_irq_deadtime.sv
// timer1 compare d channel, match/overflow flags, interrupt mask and dead time
`include "timer1_defs.svh"
`default_nettype none

module timer1_compare_irq_deadtime (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire timer1_pkg::io_req_t i_io,
  input wire timer1_pkg::core_in_t i_core,
  input wire timer1_pkg::count_mode_t i_mode,
  input wire timer1_pkg::cpu_in_t i_cpu,
  input wire logic [2:0] i_wave,
  output logic [7:0] o_io_rdata,
  output logic [9:0] o_compare_value_d,
  output logic o_irq_req,
  output logic [4:0] o_irq_vector,
  output logic [2:0] o_pwm_true,
  output logic [2:0] o_pwm_comp
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // a counted step landing on the value; a bus write to the counter
  // never raises count_step, so it cannot fake a match
  function automatic logic hit(input logic step, input logic [9:0] cnt,
                               input logic [9:0] cmp);
    hit = step && (cnt == cmp);
  endfunction

  // one dead time edge: level held low until the delay has run out
  function automatic logic [4:0] dt_step(input logic lvl, input logic prev,
                                         input logic [3:0] cnt,
                                         input logic [3:0] dly,
                                         input logic tick);
    logic [3:0] c;
    logic rise;
    c = cnt;
    rise = lvl && !prev;
    if (rise) begin
      c = dly;
    end else if (lvl && tick && (c != 4'h0)) begin
      c = c - 4'h1;
    end
    // the output only rises once the loaded delay has run down to zero;
    // a fall goes straight through, which is what opens the dead band
    dt_step = {lvl && (c == 4'h0), c};
  endfunction

  function automatic logic is_write(input timer1_pkg::io_req_t r, input logic [5:0] a);
    is_write = r.we && (r.addr == a);
  endfunction

  // which flag a taken vector owns; any other vector clears nothing
  function automatic logic [7:0] ack_mask(input timer1_pkg::cpu_in_t c);
    ack_mask = `T1_RST_BYTE;
    if (c.irq_ack) begin
      case (c.ack_vector)
        `T1_VEC_D: ack_mask[`T1_BIT_D] = 1'b1;
        `T1_VEC_A: ack_mask[`T1_BIT_A] = 1'b1;
        `T1_VEC_B: ack_mask[`T1_BIT_B] = 1'b1;
        `T1_VEC_OVF: ack_mask[`T1_BIT_OVF] = 1'b1;
        default: ack_mask = `T1_RST_BYTE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] irq_mask;
  logic [7:0] next_irq_mask;
  logic [9:0] cmp_d;
  logic [9:0] next_cmp_d;
  logic [7:0] dead_time;
  logic [7:0] next_dead_time;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] flags;
  logic [7:0] next_flags;

  // interrupt mask: all eight bits stored, only 7, 6, 5 and 2 drive requests
  always_comb begin
    next_irq_mask = irq_mask;
    if (is_write(i_io, `T1_ADDR_MASK)) begin
      next_irq_mask = i_io.wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      irq_mask <= `T1_RST_BYTE;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // compare d value; the upper two bits come from the shared high bits,
  // so software has to load those before the low byte
  always_comb begin
    next_cmp_d = cmp_d;
    if (is_write(i_io, `T1_ADDR_CMP_D)) begin
      // low byte write commits all ten bits at once
      next_cmp_d = {i_core.shared_high_bits, i_io.wdata};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cmp_d <= `T1_RST_CMP;
    end else begin
      cmp_d <= next_cmp_d;
    end
  end

  // dead time value, one copy for every channel
  always_comb begin
    next_dead_time = dead_time;
    if (is_write(i_io, `T1_ADDR_DEAD)) begin
      next_dead_time = i_io.wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      dead_time <= `T1_RST_BYTE;
    end else begin
      dead_time <= next_dead_time;
    end
  end

  // read data stands until the next read; unmapped reads give zero
  always_comb begin
    next_rdata = rdata;
    if (i_io.re) begin
      case (i_io.addr)
        `T1_ADDR_FLAGS: next_rdata = flags;
        `T1_ADDR_MASK: next_rdata = irq_mask;
        `T1_ADDR_CMP_D: next_rdata = cmp_d[7:0];
        `T1_ADDR_DEAD: next_rdata = dead_time;
        default: next_rdata = `T1_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata <= `T1_RST_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match and overflow events, one sync stage before the flags

  logic [9:0] prev_count;
  logic [9:0] next_prev_count;
  logic [7:0] evt_sync;
  logic [7:0] next_evt_sync;
  logic [7:0] clr_pend;
  logic [7:0] next_clr_pend;
  logic ovf_evt;
  logic top_wrap;
  logic [7:0] ack_clr;

  always_comb begin
    // top_value match is what wraps the counter; a wrap is top then zero
    top_wrap = i_core.count_step && (i_core.counter_value == 10'h000)
               && (prev_count == i_core.top_value);
    case (i_mode)
      timer1_pkg::MODE_NORMAL, timer1_pkg::MODE_FAST_PWM: begin
        ovf_evt = top_wrap;
      end
      timer1_pkg::MODE_PFC_PWM, timer1_pkg::MODE_PWM6_DUAL: begin
        // dual slope: zero clocked in while running down to bottom
        ovf_evt = i_core.count_step && (i_core.counter_value == 10'h000)
                  && (prev_count != 10'h000);
      end
      default: ovf_evt = 1'b0;
    endcase
    next_prev_count = i_core.count_step ? i_core.counter_value : prev_count;
    next_evt_sync = `T1_RST_BYTE;
    next_evt_sync[`T1_BIT_D] = hit(i_core.count_step, i_core.counter_value, cmp_d);
    next_evt_sync[`T1_BIT_A] = hit(i_core.count_step, i_core.counter_value,
                                   i_core.compare_value_a);
    next_evt_sync[`T1_BIT_B] = hit(i_core.count_step, i_core.counter_value,
                                   i_core.compare_value_b);
    next_evt_sync[`T1_BIT_OVF] = ovf_evt;
    // acknowledge of a taken vector clears its own flag
    ack_clr = ack_mask(i_cpu);
    // written ones wait one sync cycle; writing zero leaves flags alone
    next_clr_pend = is_write(i_io, `T1_ADDR_FLAGS)
                    ? (i_io.wdata & `T1_FLAG_MASK) : `T1_RST_BYTE;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      prev_count <= `T1_RST_CMP;
      evt_sync <= `T1_RST_BYTE;
      clr_pend <= `T1_RST_BYTE;
    end else begin
      prev_count <= next_prev_count;
      evt_sync <= next_evt_sync;
      clr_pend <= next_clr_pend;
    end
  end

  // a synced event beats a clear landing in the same cycle, so an event
  // that arrives while software clears is never lost
  always_comb begin
    next_flags = ((flags & ~(clr_pend | ack_clr)) | evt_sync)
                 & `T1_FLAG_MASK;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      flags <= `T1_RST_BYTE;
    end else begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request, lowest vector first

  logic irq_req;
  logic next_irq_req;
  logic [4:0] irq_vec;
  logic [4:0] next_irq_vec;
  logic [7:0] live;

  always_comb begin
    live = flags & irq_mask & {8{i_cpu.global_irq_en}};
    next_irq_req = 1'b1;
    if (live[`T1_BIT_A]) begin
      next_irq_vec = `T1_VEC_A;
    end else if (live[`T1_BIT_OVF]) begin
      next_irq_vec = `T1_VEC_OVF;
    end else if (live[`T1_BIT_B]) begin
      next_irq_vec = `T1_VEC_B;
    end else if (live[`T1_BIT_D]) begin
      next_irq_vec = `T1_VEC_D;
    end else begin
      next_irq_vec = `T1_VEC_NONE;
      next_irq_req = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      irq_req <= 1'b0;
      irq_vec <= `T1_VEC_NONE;
    end else begin
      irq_req <= next_irq_req;
      irq_vec <= next_irq_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dead time: every channel shares the same two delays

  logic [2:0] wave_q;
  logic [2:0] next_wave_q;
  logic [3:0] cnt_true [3];
  logic [3:0] next_cnt_true [3];
  logic [3:0] cnt_comp [3];
  logic [3:0] next_cnt_comp [3];
  logic [2:0] pwm_true;
  logic [2:0] next_pwm_true;
  logic [2:0] pwm_comp;
  logic [2:0] next_pwm_comp;

  always_comb begin
    logic [4:0] rt;
    logic [4:0] rc;
    rt = 5'h00;
    rc = 5'h00;
    next_wave_q = i_wave;
    for (int ch = 0; ch < 3; ch++) begin
      rt = dt_step(i_wave[ch], wave_q[ch], cnt_true[ch],
                   dead_time[`T1_DT_TRUE_HI:`T1_DT_TRUE_LO],
                   i_core.prescale_tick);
      rc = dt_step(!i_wave[ch], !wave_q[ch], cnt_comp[ch],
                   dead_time[`T1_DT_COMP_HI:`T1_DT_COMP_LO],
                   i_core.prescale_tick);
      next_pwm_true[ch] = rt[4];
      next_cnt_true[ch] = rt[3:0];
      next_pwm_comp[ch] = rc[4];
      next_cnt_comp[ch] = rc[3:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wave_q <= 3'h0;
      pwm_true <= 3'h0;
      pwm_comp <= 3'h0;
      for (int ch = 0; ch < 3; ch++) begin
        cnt_true[ch] <= 4'h0;
        cnt_comp[ch] <= 4'h0;
      end
    end else begin
      wave_q <= next_wave_q;
      pwm_true <= next_pwm_true;
      pwm_comp <= next_pwm_comp;
      for (int ch = 0; ch < 3; ch++) begin
        cnt_true[ch] <= next_cnt_true[ch];
        cnt_comp[ch] <= next_cnt_comp[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign o_io_rdata = rdata;
  assign o_compare_value_d = cmp_d;
  assign o_irq_req = irq_req;
  assign o_irq_vector = irq_vec;
  assign o_pwm_true = pwm_true;
  assign o_pwm_comp = pwm_comp;

endmodule // timer1_compare_irq_deadtime
`default_nettype wire

// >>> logic/timer1_defs.svh
// register offsets, field positions, reset values for the timer1 block
`ifndef TIMER1_DEFS_SVH
`define TIMER1_DEFS_SVH
`define T1_ADDR_FLAGS 6'h38
`define T1_ADDR_MASK 6'h39
`define T1_ADDR_CMP_D 6'h3a
`define T1_ADDR_DEAD 6'h3b
`define T1_BIT_D 7
`define T1_BIT_A 6
`define T1_BIT_B 5
`define T1_BIT_OVF 2
`define T1_FLAG_MASK 8'he4
`define T1_RST_BYTE 8'h00
`define T1_RST_CMP 10'h000
`define T1_DT_TRUE_HI 7
`define T1_DT_TRUE_LO 4
`define T1_DT_COMP_HI 3
`define T1_DT_COMP_LO 0
`define T1_VEC_A 5'h03
`define T1_VEC_OVF 5'h04
`define T1_VEC_B 5'h09
`define T1_VEC_D 5'h10
`define T1_VEC_NONE 5'h00
`define T1_SYNC_STAGES 1
`endif

// >>> logic/timer1_pkg.sv
// types shared by the timer1 compare, interrupt and dead time block
`default_nettype none
package timer1_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FAST_PWM,
    MODE_PFC_PWM,
    MODE_PWM6_DUAL
  } count_mode_t;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } io_req_t;
  typedef struct packed {
    logic [9:0] counter_value;
    logic [9:0] top_value;
    logic [9:0] compare_value_a;
    logic [9:0] compare_value_b;
    logic [1:0] shared_high_bits;
    logic count_step;
    logic prescale_tick;
  } core_in_t;
  typedef struct packed {
    logic irq_ack;
    logic [4:0] ack_vector;
    logic global_irq_en;
  } cpu_in_t;
endpackage
`default_nettype wire

// >>> dv/timer1_compare_irq_deadtime_assertions.sv
// port checker for the timer1 compare, flag, interrupt and dead time block
`default_nettype none
module timer1_compare_irq_deadtime_assertions (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire timer1_pkg::io_req_t i_io,
  input wire timer1_pkg::core_in_t i_core,
  input wire timer1_pkg::count_mode_t i_mode,
  input wire timer1_pkg::cpu_in_t i_cpu,
  input wire logic [2:0] i_wave,
  input wire logic [7:0] o_io_rdata,
  input wire logic [9:0] o_compare_value_d,
  input wire logic o_irq_req,
  input wire logic [4:0] o_irq_vector,
  input wire logic [2:0] o_pwm_true,
  input wire logic [2:0] o_pwm_comp
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_cmp_wr;
    i_io.we && i_io.addr == 6'h3a |=>
      o_compare_value_d == {$past(i_core.shared_high_bits), $past(i_io.wdata)};
  endproperty
  a_cmp_wr: assert property (p_cmp_wr) else $error("compare d write lost");
  property p_cmp_rd;
    i_io.re && !i_io.we && i_io.addr == 6'h3a |=> o_io_rdata == o_compare_value_d[7:0];
  endproperty
  a_cmp_rd: assert property (p_cmp_rd) else $error("compare d read wrong");
  property p_flag_rsvd;
    i_io.re && i_io.addr == 6'h38 |=> o_io_rdata[4:3] == 2'b00 && o_io_rdata[1:0] == 2'b00;
  endproperty
  a_flag_rsvd: assert property (p_flag_rsvd) else $error("foreign flag bits read");
  property p_gie;
    !i_cpu.global_irq_en |=> !o_irq_req;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_vec;
    o_irq_req |-> o_irq_vector inside {5'h03, 5'h04, 5'h09, 5'h10};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_true_fall;
    $fell(i_wave[0]) |=> !o_pwm_true[0];
  endproperty
  a_true_fall: assert property (p_true_fall) else $error("true output fall late");
  property p_true_rise;
    $rose(o_pwm_true[0]) |-> $past(i_wave[0]);
  endproperty
  a_true_rise: assert property (p_true_rise) else $error("true output rise uncaused");
  property p_comp_fall;
    $rose(i_wave[0]) |=> !o_pwm_comp[0];
  endproperty
  a_comp_fall: assert property (p_comp_fall) else $error("complement fall late");
  ////////////////////////////////////////////////////////////////////////////////
  c_irq_d: cover property (o_irq_req && o_irq_vector == 5'h10);
  c_irq_ovf: cover property (o_irq_req && o_irq_vector == 5'h04);
  c_dead: cover property ($rose(o_pwm_true[2]));
endmodule // timer1_compare_irq_deadtime_assertions

bind timer1_compare_irq_deadtime timer1_compare_irq_deadtime_assertions u_chk (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_io(i_io), .i_core(i_core), .i_mode(i_mode),
  .i_cpu(i_cpu), .i_wave(i_wave), .o_io_rdata(o_io_rdata),
  .o_compare_value_d(o_compare_value_d), .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector),
  .o_pwm_true(o_pwm_true), .o_pwm_comp(o_pwm_comp));
`default_nettype wire

// >>> dv/timer1_compare_irq_deadtime_tb_top.sv
// self-checking bench for the timer1 compare, flag, interrupt and dead time block
`default_nettype none
module timer1_compare_irq_deadtime_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  timer1_pkg::io_req_t io = '0;
  timer1_pkg::core_in_t core = '0;
  timer1_pkg::count_mode_t mode = timer1_pkg::MODE_NORMAL;
  timer1_pkg::cpu_in_t cpu = '0;
  logic [2:0] wave = 3'h0;
  logic [7:0] rdata;
  logic [9:0] cmp_d;
  logic irq;
  logic [4:0] vec;
  logic [2:0] pt, pc;
  int err_total = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  timer1_compare_irq_deadtime u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_io(io), .i_core(core),
    .i_mode(mode), .i_cpu(cpu), .i_wave(wave), .o_io_rdata(rdata), .o_compare_value_d(cmp_d),
    .o_irq_req(irq), .o_irq_vector(vec), .o_pwm_true(pt), .o_pwm_comp(pc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each access so strobes never toggle twice in a step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io.addr = a;
    io.wdata = d;
    io.we = 1'b1;
    cyc(1);
    io.we = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    io.addr = a;
    io.re = 1'b1;
    cyc(1);
    io.re = 1'b0;
    cyc(1);
    chk({2'b00, rdata}, {2'b00, exp});
  endtask
  // counting step, then room for sync stage and request
  task automatic step(input logic [9:0] v);
    core.counter_value = v;
    core.count_step = 1'b1;
    cyc(1);
    core.count_step = 1'b0;
    cyc(4);
  endtask
  task automatic ack(input logic [4:0] v);
    cpu.ack_vector = v;
    cpu.irq_ack = 1'b1;
    cyc(1);
    cpu.irq_ack = 1'b0;
    cyc(1);
  endtask
  task automatic tick;
    core.prescale_tick = 1'b1;
    cyc(1);
    core.prescale_tick = 1'b0;
    cyc(2);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core.top_value = 10'h0ff;
    core.compare_value_a = 10'h100;
    core.compare_value_b = 10'h180;
    core.shared_high_bits = 2'b10;
    core.counter_value = 10'h25a;
    cpu.global_irq_en = 1'b1;
    cyc(16);
    rstn = 1'b1;
    rd(6'h38, 8'h00);
    rd(6'h39, 8'h00);
    wr(6'h39, 8'he4);
    rd(6'h39, 8'he4);
    wr(6'h3b, 8'h21);
    rd(6'h3b, 8'h21);
    wr(6'h3a, 8'h5a);
    chk(cmp_d, 10'h25a);
    rd(6'h3a, 8'h5a);
    cyc(3);
    rd(6'h38, 8'h00);
    step(10'h25a);
    rd(6'h38, 8'h80);
    chk({4'h0, irq, vec}, 10'h030);
    ack(5'h10);
    rd(6'h38, 8'h00);
    step(10'h100);
    step(10'h25a);
    rd(6'h38, 8'hc0);
    chk({4'h0, irq, vec}, 10'h023);
    wr(6'h38, 8'h00);
    rd(6'h38, 8'hc0);
    wr(6'h38, 8'h40);
    cyc(1);
    rd(6'h38, 8'h80);
    wr(6'h38, 8'h80);
    step(10'h180);
    rd(6'h38, 8'h20);
    chk({4'h0, irq, vec}, 10'h029);
    wr(6'h38, 8'h20);
    step(10'h050);
    step(10'h000);
    rd(6'h38, 8'h00);
    // modes 0,1 wrap at top, modes 2,3 turn at bottom
    for (int m = 0; m < 4; m++) begin
      mode = timer1_pkg::count_mode_t'(m);
      step(m < 2 ? 10'h0ff : 10'h001);
      step(10'h000);
      rd(6'h38, 8'h04);
      chk({4'h0, irq, vec}, 10'h024);
      cpu.global_irq_en = 1'b0;
      cyc(2);
      chk({4'h0, irq, vec}, 10'h000);
      cpu.global_irq_en = 1'b1;
      wr(6'h38, 8'h04);
    end
    wave = 3'b111;
    cyc(2);
    chk({4'h0, pt, pc}, 10'h000);
    tick;
    chk({4'h0, pt, pc}, 10'h000);
    tick;
    chk({4'h0, pt, pc}, 10'h038);
    wave = 3'b000;
    cyc(2);
    chk({4'h0, pt, pc}, 10'h000);
    tick;
    chk({4'h0, pt, pc}, 10'h007);
    wr(6'h3b, 8'h00);
    wave = 3'b111;
    cyc(2);
    chk({4'h0, pt, pc}, 10'h038);
    step(10'h100);
    ack(5'h03);
    rd(6'h38, 8'h00);
    step(10'h180);
    step(10'h000);
    rd(6'h38, 8'h24);
    ack(5'h09);
    ack(5'h04);
    rd(6'h38, 8'h00);
    // event and write-one clear land on the same edge: the event wins
    io.addr = 6'h38;
    io.wdata = 8'h40;
    io.we = 1'b1;
    core.counter_value = 10'h100;
    core.count_step = 1'b1;
    cyc(1);
    io.we = 1'b0;
    core.count_step = 1'b0;
    cyc(4);
    rd(6'h38, 8'h40);
    stop_test;
  end
  // whole run is a few hundred cycles
  initial begin
    #50000;
    err_total++;
    stop_test;
  end
endmodule // timer1_compare_irq_deadtime_tb_top
`default_nettype wire
